// ### rsc_pin_drv.sv
// external reset circuitry model pulling the reset pin low
`timescale 1ns/100ps
module rsc_pin_drv (
  input  wire logic       mclk,
  input  wire logic       go,
  input  wire logic [7:0] len,
  output      logic       pin_n
);
  logic [7:0] cnt = 8'h00;
  always @(posedge mclk) begin
    if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end else if (go) begin
      cnt <= len;
    end
  end
  // released pin rests high on its pull-up
  assign pin_n = (cnt == 8'h00);
endmodule

// ### rsc_pkg.sv
// shared constants and types for the reset source controller
package rsc_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] RSC_REG_ADDR     = 8'hef;
  localparam int         RSC_PIN_BIT      = 0;
  localparam int         RSC_POWER_BIT    = 1;
  localparam int         RSC_CLKLOSS_BIT  = 2;
  localparam int         RSC_WDOG_BIT     = 3;
  localparam int         RSC_SOFT_BIT     = 4;
  localparam int         RSC_CMP_BIT      = 5;
  localparam int         RSC_FLASH_BIT    = 6;
  localparam logic [7:0] RSC_FLAGS_RESET  = 8'h02;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS    = 100;
  localparam int MCD_TIMEOUT_US   = 100;
  // longest time: round down
  localparam int MCD_TIMEOUT_CYC  = (MCD_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int WDOG_DIV         = 12;
  localparam int WDOG_LIMIT_RESET = 255;
  localparam logic [15:0] USER_CODE_LIMIT = 16'h1dff;

  // ************************************************************
  // sequencer states and reset source codes
  // ************************************************************
  typedef enum logic [2:0] {
    RSC_RUN  = 3'b001,
    RSC_HOLD = 3'b010,
    RSC_REL  = 3'b100
  } rsc_state_t;

  typedef enum logic [2:0] {
    SRC_NONE  = 3'd0,
    SRC_PIN   = 3'd1,
    SRC_CLK   = 3'd2,
    SRC_CMP   = 3'd3,
    SRC_WDOG  = 3'd4,
    SRC_FLASH = 3'd5,
    SRC_SOFT  = 3'd6
  } rsc_src_t;
endpackage

// ### rsc_properties.sv
// port checker for the reset source controller, bound to its top
`timescale 1ns/100ps
module rsc_properties
  import rsc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        ext_reset_n,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        security_block,
  input wire logic        prog_store_write_enable,
  input wire logic        external_data_move,
  input wire logic        code_space_read,
  input wire logic        branch_taken,
  input wire logic [15:0] access_addr,
  input wire logic        sys_reset,
  input wire logic        ext_reset_oe
);
  // ************************************************************
  // assertions
  // ************************************************************
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic above;
  assign above = access_addr > USER_CODE_LIMIT;

  AST_PIN_ENTER: assert property ($fell(ext_reset_n) && !sys_reset |-> ##[1:4] sys_reset)
    else $error("pin low gave no reset");
  AST_PIN_HOLD: assert property (!ext_reset_n [*5] |-> sys_reset)
    else $error("reset dropped while pin low");
  AST_PIN_EXIT: assert property ($rose(ext_reset_n) |-> ##[1:6] !sys_reset)
    else $error("reset stuck after pin release");
  AST_SOFT: assert property (reg_wr && reg_addr == RSC_REG_ADDR && reg_wdata[4] && !sys_reset
    |=> sys_reset [*2] ##1 !sys_reset)
    else $error("soft reset sequence wrong");
  AST_SECURE: assert property (security_block && !sys_reset |=> sys_reset)
    else $error("blocked access gave no reset");
  AST_DATA_WR: assert property (prog_store_write_enable && external_data_move && above
    && !sys_reset |=> sys_reset)
    else $error("store write above limit gave no reset");
  AST_CODE_RD: assert property (code_space_read && above && !sys_reset |=> sys_reset)
    else $error("code read above limit gave no reset");
  AST_BRANCH: assert property (branch_taken && above && !sys_reset |=> sys_reset)
    else $error("branch above limit gave no reset");
  AST_NO_DRIVE: assert property (!ext_reset_oe)
    else $error("reset pin driven");

  cover property (reg_wr && reg_wdata[4] && reg_addr == RSC_REG_ADDR);
  cover property (!ext_reset_n && sys_reset);
  cover property (security_block && !sys_reset);
endmodule

bind rsc_top rsc_properties u_props (.mclk(mclk), .nrst(nrst), .ext_reset_n(ext_reset_n),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .security_block(security_block), .prog_store_write_enable(prog_store_write_enable),
  .external_data_move(external_data_move), .code_space_read(code_space_read),
  .branch_taken(branch_taken), .access_addr(access_addr), .sys_reset(sys_reset),
  .ext_reset_oe(ext_reset_oe));

// ### rsc_top.sv
// reset source controller: collects reset causes and keeps the source register
// Operation
// RQ1: low external reset pin resets device; pin flag bit 0 set on exit
// RQ2: missing-clock one-shot retriggered by clock edges; timeout causes reset
// RQ3: clock-loss flag bit 2 reads one only after missing-clock reset
// RQ4: writing bit 2 enables or disables the missing-clock detector
// RQ5: writing bit 5 selects or deselects comparator as reset source
// RQ6: enabled comparator holds reset while non-inverting below inverting input
// RQ7: bit 5 reads one only after a comparator reset
// RQ8: software should let comparator settle before selecting it
// RQ9: watchdog comes up enabled, clocked at system clock over twelve
// RQ10: watchdog timeout resets device and sets flag bit 3
// RQ11: data write above code limit with store writing enabled resets
// RQ12: code-space read above code limit resets device
// RQ13: branch above code limit resets device
// RQ14: flash access blocked by security resets device
// RQ15: any flash error reset sets flag bit 6
// RQ16: writing one to bit 4 forces reset; bit reads one after
// RQ17: internal sources never drive the external reset pin
// RQ18: only the causing source flag reads one; enables keep values
`timescale 1ns/100ps
module rsc_top
  import rsc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ext_reset_n,
  input  wire logic        power_on_event,
  input  wire logic        cmp_out,
  input  wire logic        system_clock_mon,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output      logic [7:0]  reg_rdata,
  input  wire logic        prog_store_write_enable,
  input  wire logic        external_data_move,
  input  wire logic        code_space_read,
  input  wire logic        branch_taken,
  input  wire logic [15:0] access_addr,
  input  wire logic        security_block,
  input  wire logic        wdog_service,
  input  wire logic        wdog_disable,
  input  wire logic [7:0]  wdog_limit,
  output      logic        sys_reset,
  output      logic        ext_reset_o,
  output      logic        ext_reset_oe
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [1:0]             pin_sync;
    logic [1:0]             cmp_sync;
    logic [1:0]             clk_sync;
    logic                   clk_last;
    logic [$clog2(MCD_TIMEOUT_CYC+1)-1:0] mcd_cnt;
    logic                   mcd_en;
    logic                   cmp_en;
    logic                   power_en;
    logic [7:0]             flags;
    rsc_src_t               cause;
    rsc_state_t             state;
    logic [7:0]             rdata;
  } rsc_regs_t;

  localparam int MCD_W = $clog2(MCD_TIMEOUT_CYC+1);

  rsc_regs_t cur;
  rsc_regs_t next_cur;
  rsc_wdog_if wd ();

  rsc_wdog u_wdog (
    .mclk (mclk),
    .nrst (nrst),
    .bus  (wd.wdog)
  );

  function automatic logic above_limit(input logic [15:0] a);
    return a > USER_CODE_LIMIT;
  endfunction

  // ************************************************************
  // source detection
  // ************************************************************
  logic     pin_low;
  logic     cmp_low;
  logic     clk_edge;
  logic     mcd_timeout;
  logic     flash_err;
  logic     soft_req;
  logic     reg_hit;
  rsc_src_t src_now;

  always_comb begin
    pin_low     = !cur.pin_sync[1]; // [RQ1]
    cmp_low     = cur.cmp_en && !cur.cmp_sync[1]; // [RQ6]
    clk_edge    = cur.clk_sync[1] != cur.clk_last; // [RQ2]
    mcd_timeout = cur.mcd_en && (cur.mcd_cnt >= MCD_W'(MCD_TIMEOUT_CYC)); // [RQ2]
    flash_err   = (external_data_move && prog_store_write_enable
                   && above_limit(access_addr)) // [RQ11]
                || (code_space_read && above_limit(access_addr)) // [RQ12]
                || (branch_taken && above_limit(access_addr)) // [RQ13]
                || security_block; // [RQ14]
    reg_hit     = reg_addr == RSC_REG_ADDR;
    soft_req    = reg_wr && reg_hit && reg_wdata[RSC_SOFT_BIT]; // [RQ16]
    if (pin_low) begin
      src_now = SRC_PIN;
    end else if (mcd_timeout) begin
      src_now = SRC_CLK;
    end else if (cmp_low) begin
      src_now = SRC_CMP;
    end else if (wd.expire) begin
      src_now = SRC_WDOG;
    end else if (flash_err) begin
      src_now = SRC_FLASH;
    end else if (soft_req) begin
      src_now = SRC_SOFT;
    end else begin
      src_now = SRC_NONE;
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_cur          = cur;
    next_cur.pin_sync = {cur.pin_sync[0], ext_reset_n};
    next_cur.cmp_sync = {cur.cmp_sync[0], cmp_out};
    next_cur.clk_sync = {cur.clk_sync[0], system_clock_mon};
    next_cur.clk_last = cur.clk_sync[1];
    // one-shot retriggered on every monitored clock edge
    if (clk_edge || !cur.mcd_en) begin
      next_cur.mcd_cnt = '0; // [RQ2]
    end else if (!mcd_timeout) begin
      next_cur.mcd_cnt = cur.mcd_cnt + MCD_W'(1);
    end

    unique case (cur.state)
      RSC_RUN: begin
        if (src_now != SRC_NONE) begin
          next_cur.cause = src_now;
          next_cur.state = RSC_HOLD;
        end else if (power_on_event) begin
          next_cur.flags = RSC_FLAGS_RESET;
        end else if (reg_wr && reg_hit) begin
          next_cur.mcd_en   = reg_wdata[RSC_CLKLOSS_BIT]; // [RQ4]
          next_cur.cmp_en   = reg_wdata[RSC_CMP_BIT]; // [RQ5]
          next_cur.power_en = reg_wdata[RSC_POWER_BIT];
        end
      end
      RSC_HOLD: begin
        // level sources keep the device in reset until they go away
        if (!pin_low && !cmp_low) begin
          next_cur.state = RSC_REL;
        end
        if (cur.cause == SRC_CLK) begin
          next_cur.mcd_cnt = '0;
        end
      end
      RSC_REL: begin
        next_cur.flags = 8'h00; // [RQ18]
        unique case (cur.cause)
          SRC_PIN:   next_cur.flags[RSC_PIN_BIT]     = 1'b1; // [RQ1]
          SRC_CLK:   next_cur.flags[RSC_CLKLOSS_BIT] = 1'b1; // [RQ3]
          SRC_CMP:   next_cur.flags[RSC_CMP_BIT]     = 1'b1; // [RQ7]
          SRC_WDOG:  next_cur.flags[RSC_WDOG_BIT]    = 1'b1; // [RQ10]
          SRC_FLASH: next_cur.flags[RSC_FLASH_BIT]   = 1'b1; // [RQ15]
          SRC_SOFT:  next_cur.flags[RSC_SOFT_BIT]    = 1'b1; // [RQ16]
          default:   next_cur.flags                  = 8'h00;
        endcase
        next_cur.state = RSC_RUN;
      end
      default: next_cur.state = RSC_RUN;
    endcase

    // flags read back; bit 7 always zero
    next_cur.rdata = reg_rd && reg_hit ? {1'b0, cur.flags[6:0]} : 8'h00;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cur <= '{pin_sync: 2'h3, cmp_sync: 2'h3, clk_sync: 2'h0, clk_last: 1'b0,
               mcd_cnt: '0, mcd_en: 1'b0, cmp_en: 1'b0, power_en: 1'b0,
               flags: RSC_FLAGS_RESET, cause: SRC_NONE, state: RSC_RUN,
               rdata: 8'h00};
    end else begin
      cur <= next_cur;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // the pin is only ever an input here; internal causes never pull it low
  assign ext_reset_o  = 1'b0; // [RQ17]
  assign ext_reset_oe = 1'b0; // [RQ17]
  assign sys_reset    = cur.state != RSC_RUN;
  assign reg_rdata    = cur.rdata;

  assign wd.sys_rst     = cur.state != RSC_RUN; // [RQ9]
  assign wd.service     = wdog_service;
  assign wd.disable_req = wdog_disable;
  assign wd.limit       = wdog_limit;
endmodule

// ### rsc_wdog.sv
// counter-array watchdog clocked at one twelfth of the system clock
`timescale 1ns/100ps
module rsc_wdog
  import rsc_pkg::*;
(
  input  wire logic mclk,
  input  wire logic nrst,
  rsc_wdog_if.wdog  bus
);
  typedef struct packed {
    logic [3:0] pre;
    logic [7:0] count;
    logic       enabled;
    logic       expire;
  } rsc_wd_t;

  rsc_wd_t cur;
  rsc_wd_t next_cur;

  always_comb begin
    next_cur        = cur;
    next_cur.expire = 1'b0;
    if (bus.sys_rst) begin
      // comes up enabled after every reset [RQ9]
      next_cur.pre     = '0;
      next_cur.count   = '0;
      next_cur.enabled = 1'b1;
    end else begin
      if (bus.disable_req) begin
        next_cur.enabled = 1'b0;
      end
      if (bus.service) begin
        next_cur.count = '0;
        next_cur.pre   = '0;
      end else if (cur.enabled) begin
        if (cur.pre == 4'(WDOG_DIV - 1)) begin // [RQ9]
          next_cur.pre = '0;
          if (cur.count >= bus.limit) begin
            next_cur.expire = 1'b1; // [RQ10]
            next_cur.count  = '0;
          end else begin
            next_cur.count = cur.count + 8'h01;
          end
        end else begin
          next_cur.pre = cur.pre + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cur <= '{pre: 4'h0, count: 8'h00, enabled: 1'b1, expire: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign bus.expire = cur.expire;
endmodule

// ### rsc_wdog_if.sv
// watchdog control/status carrier between controller and watchdog
`timescale 1ns/100ps
interface rsc_wdog_if;
  logic       sys_rst;
  logic       service;
  logic       disable_req;
  logic [7:0] limit;
  logic       expire;
  modport ctrl (output sys_rst, output service, output disable_req, output limit, input expire);
  modport wdog (input sys_rst, input service, input disable_req, input limit, output expire);
endinterface

// ### testbench.sv
// self-checking testbench for the reset source controller
`timescale 1ns/100ps
module testbench;
  import rsc_pkg::*;
  typedef struct packed {logic [7:0] pre; logic [3:0] code; logic [7:0] flags;} rsc_row_t;
  localparam rsc_row_t ROWS [9] = '{
    '{8'h00, 4'h0, 8'h10}, '{8'h00, 4'h1, 8'h01}, '{8'h00, 4'h2, 8'h40},
    '{8'h00, 4'h3, 8'h40}, '{8'h00, 4'h4, 8'h40}, '{8'h00, 4'h5, 8'h40},
    '{8'h00, 4'h6, 8'h08}, '{8'h20, 4'h7, 8'h20}, '{8'h04, 4'h8, 8'h04}};
  logic        mclk, nrst, ext_reset_n, cmp_out, system_clock_mon, reg_wr, reg_rd, sys_reset;
  logic        prog_store_write_enable, external_data_move, code_space_read, branch_taken;
  logic        security_block, wdog_service, ext_reset_o, ext_reset_oe, pin_go, svc_on, clk_on;
  logic        wdog_disable;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, pin_len;
  logic [15:0] access_addr;
  logic [3:0]  cyc;
  int          errors, tests_run;

  rsc_top uut (.mclk(mclk), .nrst(nrst), .ext_reset_n(ext_reset_n), .power_on_event(1'b0),
    .cmp_out(cmp_out), .system_clock_mon(system_clock_mon), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .prog_store_write_enable(prog_store_write_enable), .external_data_move(external_data_move),
    .code_space_read(code_space_read), .branch_taken(branch_taken), .access_addr(access_addr),
    .security_block(security_block), .wdog_service(wdog_service), .wdog_disable(wdog_disable),
    .wdog_limit(8'h04), .sys_reset(sys_reset), .ext_reset_o(ext_reset_o),
    .ext_reset_oe(ext_reset_oe));
  rsc_pin_drv u_pin (.mclk(mclk), .go(pin_go), .len(pin_len), .pin_n(ext_reset_n));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // watchdog serviced every 16 cycles, well inside its 60-cycle limit
  always @(posedge mclk) begin
    cyc <= cyc + 4'h1;
    wdog_service <= svc_on && (cyc == 4'h0);
    if (clk_on) system_clock_mon <= ~system_clock_mon;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic go(input logic [3:0] c);
    @(posedge mclk);
    case (c)
      4'h0: begin reg_wr <= 1'b1; reg_addr <= RSC_REG_ADDR; reg_wdata <= 8'h10; end
      4'h1: pin_go <= 1'b1;
      4'h2: security_block <= 1'b1;
      4'h3: begin prog_store_write_enable <= 1'b1; external_data_move <= 1'b1; end
      4'h4: code_space_read <= 1'b1;
      4'h5: branch_taken <= 1'b1;
      4'h6: svc_on <= 1'b0;
      4'h7: cmp_out <= 1'b0;
      default: clk_on <= 1'b0;
    endcase
    @(posedge mclk);
    {reg_wr, pin_go, security_block, external_data_move, code_space_read, branch_taken} <= 6'h00;
  endtask
  // waits out one reset, undoing the fault once it has been seen
  task automatic settle();
    int n;
    n = 0;
    while (sys_reset !== 1'b1 && n < 1500) begin @(posedge mclk); #1; n++; end
    chk({7'h00, sys_reset}, 8'h01);
    chk({6'h00, ext_reset_o, ext_reset_oe}, 8'h00);
    // undo the fault on a clock edge, never between edges
    @(posedge mclk);
    cmp_out <= 1'b1; svc_on <= 1'b1; clk_on <= 1'b1; prog_store_write_enable <= 1'b0;
    n = 0;
    while (sys_reset !== 1'b0 && n < 1500) begin @(posedge mclk); #1; n++; end
    chk({7'h00, sys_reset}, 8'h00);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    {nrst, reg_wr, reg_rd, prog_store_write_enable, external_data_move} = 5'h00;
    {code_space_read, branch_taken, security_block, pin_go, system_clock_mon} = 5'h00;
    wdog_disable = 1'b0;
    {cmp_out, svc_on, clk_on} = 3'h7;
    {reg_addr, reg_wdata, pin_len, cyc, errors, tests_run} = '0;
    access_addr = 16'h1e00;
    pin_len = 8'h05;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      if (ROWS[i].pre != 8'h00) wr(RSC_REG_ADDR, ROWS[i].pre);
      go(ROWS[i].code);
      settle();
      rd(RSC_REG_ADDR, ROWS[i].flags);
      wr(RSC_REG_ADDR, 8'h00);
      $display("row %0d done", i);
    end
    rd(8'hee, 8'h00);
    @(posedge mclk);
    access_addr <= 16'h1dff;
    go(4'h3); go(4'h4); go(4'h5);
    prog_store_write_enable <= 1'b0;
    repeat (4) @(posedge mclk);
    #1 chk({7'h00, sys_reset}, 8'h00);
    $display("limit boundary done");
    pin_len <= 8'h28;
    go(4'h1);
    repeat (30) @(posedge mclk);
    #1 chk({7'h00, sys_reset}, 8'h01);
    settle();
    rd(RSC_REG_ADDR, 8'h01);
    $display("long pin done");
    @(posedge mclk);
    nrst <= 1'b0;
    @(posedge mclk);
    nrst <= 1'b1;
    rd(RSC_REG_ADDR, RSC_FLAGS_RESET);
    $display("mid-run reset done");
    // disabled watchdog stays quiet, then comes back after the next reset
    @(posedge mclk);
    wdog_disable <= 1'b1;
    svc_on <= 1'b0;
    @(posedge mclk);
    wdog_disable <= 1'b0;
    repeat (100) @(posedge mclk);
    rd(RSC_REG_ADDR, RSC_FLAGS_RESET);
    go(4'h0);
    settle();
    rd(RSC_REG_ADDR, 8'h10);
    @(posedge mclk);
    svc_on <= 1'b0;
    settle();
    rd(RSC_REG_ADDR, 8'h08);
    $display("watchdog re-enable done");
    complete_run();
  end
  initial begin
    #2000000;
    errors++;
    complete_run();
  end
endmodule
